// ==== pkg/ddmsc_defines.svh ====
// Opcodes, result codes, reset values and timing counts of the command sequencer
`ifndef DDMSC_DEFINES_SVH
`define DDMSC_DEFINES_SVH

`define DDMSC_OP_DIAG        8'h90
`define DDMSC_OP_SET_PARAM   8'h91
`define DDMSC_OP_RD_MULTI    8'hc4
`define DDMSC_OP_WR_MULTI    8'hc5
`define DDMSC_OP_SET_MULTI   8'hc6

`define DDMSC_DIAG_OK        8'h01
`define DDMSC_DIAG_NA        8'h02
`define DDMSC_DIAG_BUF_RAM   8'h03
`define DDMSC_DIAG_CTL_REG   8'h04
`define DDMSC_DIAG_CPU_MEM   8'h05
`define DDMSC_DIAG_SLAVE     4'h8
`define DDMSC_ERR_ABORT      8'h04

`define DDMSC_DRV_BIT        4
`define DDMSC_MAX_BLOCK      4'h8
`define DDMSC_SPT_RST        8'h11
`define DDMSC_HEADS_RST      4'ha
`define DDMSC_FULL_COUNT     9'h100

`define DDMSC_CLK_KHZ        20000
`define DDMSC_PDIAG_WAIT_MS  5000
`define DDMSC_PDIAG_WAIT_CYC (`DDMSC_PDIAG_WAIT_MS * `DDMSC_CLK_KHZ)
`define DDMSC_INT_RAM_BYTES  2048
`define DDMSC_BUF_RAM_BYTES  8192

`endif

// ==== pkg/ddmsc_pkg.sv ====
// State types of the command sequencer and its self-test engine
package ddmsc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DIAG_RUN, ST_DIAG_WAIT, ST_XF_WAIT, ST_XF_DRQ, ST_WR_DISK, ST_DONE
  } ddmsc_state_t;

  typedef enum logic [2:0] {
    TS_IDLE, TS_ROM, TS_CTL, TS_RAM_WR, TS_RAM_RD, TS_RAM_CHK, TS_DONE
  } ddmsc_test_t;

endpackage : ddmsc_pkg

// ==== rtl/ddmsc_selftest.sv ====
// Self-test engine: ROM checksum, controller register test and RAM pattern test
`timescale 1ns/10ps
`include "ddmsc_defines.svh"

module ddmsc_selftest #(
  parameter int INT_BYTES = `DDMSC_INT_RAM_BYTES,
  parameter int BUF_BYTES = `DDMSC_BUF_RAM_BYTES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Start and result
  input  wire logic        start,
  output logic             done,
  output logic [7:0]       resultCode,
  // ROM checksum unit
  output logic             romChkReq,
  input  wire logic        romChkDone,
  input  wire logic        romChkOk,
  // Disk controller register test unit
  output logic             ctlTstReq,
  input  wire logic        ctlTstDone,
  input  wire logic        ctlTstOk,
  // RAM port, read data valid one cycle after memRe
  output logic             memSel,
  output logic [14:0]      memAddr,
  output logic             memWe,
  output logic             memRe,
  output logic [7:0]       memWrData,
  input  wire logic [7:0]  memRdData
);

  if (BUF_BYTES > 32768 || INT_BYTES > BUF_BYTES || INT_BYTES < 1) begin : g_bad_size
    $error("ddmsc_selftest: RAM sizes out of range");
  end

  ddmsc_pkg::ddmsc_test_t state_r;
  logic        romFail_r;
  logic        ctlFail_r;
  logic        intFail_r;
  logic        bufFail_r;
  logic [14:0] lastAddr;

  // Internal RAM first, then the buffer; each pass ends at its own size
  assign lastAddr  = memSel ? 15'(BUF_BYTES - 1) : 15'(INT_BYTES - 1);
  assign romChkReq = (state_r == ddmsc_pkg::TS_ROM);
  assign ctlTstReq = (state_r == ddmsc_pkg::TS_CTL);
  assign memWe     = (state_r == ddmsc_pkg::TS_RAM_WR);
  assign memRe     = (state_r == ddmsc_pkg::TS_RAM_RD);
  assign memWrData = memAddr[7:0];
  assign done      = (state_r == ddmsc_pkg::TS_DONE);

  // Test sequence; every test runs so that the worst fault is reported
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ddmsc_pkg::TS_IDLE;
    end else begin
      case (state_r)
        ddmsc_pkg::TS_IDLE:    if (start) state_r <= ddmsc_pkg::TS_ROM;
        ddmsc_pkg::TS_ROM:     if (romChkDone) state_r <= ddmsc_pkg::TS_CTL;
        ddmsc_pkg::TS_CTL:     if (ctlTstDone) state_r <= ddmsc_pkg::TS_RAM_WR;
        ddmsc_pkg::TS_RAM_WR:  if (memAddr == lastAddr) state_r <= ddmsc_pkg::TS_RAM_RD;
        ddmsc_pkg::TS_RAM_RD:  state_r <= ddmsc_pkg::TS_RAM_CHK;
        ddmsc_pkg::TS_RAM_CHK: begin
          if (memAddr != lastAddr) state_r <= ddmsc_pkg::TS_RAM_RD;
          else if (!memSel) state_r <= ddmsc_pkg::TS_RAM_WR;
          else state_r <= ddmsc_pkg::TS_DONE;
        end
        ddmsc_pkg::TS_DONE:    state_r <= ddmsc_pkg::TS_IDLE;
        default:               state_r <= ddmsc_pkg::TS_IDLE;
      endcase
    end
  end

  // Address walk and RAM selection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memAddr <= 15'h0000;
      memSel  <= 1'b0;
    end else if (state_r == ddmsc_pkg::TS_IDLE || state_r == ddmsc_pkg::TS_CTL) begin
      memAddr <= 15'h0000;
      memSel  <= 1'b0;
    end else if (state_r == ddmsc_pkg::TS_RAM_WR) begin
      memAddr <= (memAddr == lastAddr) ? 15'h0000 : memAddr + 15'h0001;
    end else if (state_r == ddmsc_pkg::TS_RAM_CHK) begin
      if (memAddr != lastAddr) begin
        memAddr <= memAddr + 15'h0001;
      end else begin
        memAddr <= 15'h0000;
        memSel  <= 1'b1;
      end
    end
  end

  // Fault flags, cleared at each start
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (state_r == ddmsc_pkg::TS_IDLE && start)) begin
      romFail_r <= 1'b0;
      ctlFail_r <= 1'b0;
      intFail_r <= 1'b0;
      bufFail_r <= 1'b0;
    end else begin
      if (state_r == ddmsc_pkg::TS_ROM && romChkDone && !romChkOk) romFail_r <= 1'b1;
      if (state_r == ddmsc_pkg::TS_CTL && ctlTstDone && !ctlTstOk) ctlFail_r <= 1'b1;
      if (state_r == ddmsc_pkg::TS_RAM_CHK && memRdData != memAddr[7:0]) begin
        if (memSel) bufFail_r <= 1'b1;
        else intFail_r <= 1'b1;
      end
    end
  end

  // Result code: processor memory outranks buffer, buffer outranks controller
  always_comb begin
    if (romFail_r || intFail_r) resultCode = `DDMSC_DIAG_CPU_MEM;
    else if (bufFail_r)         resultCode = `DDMSC_DIAG_BUF_RAM;
    else if (ctlFail_r)         resultCode = `DDMSC_DIAG_CTL_REG;
    else                        resultCode = `DDMSC_DIAG_OK;
  end

endmodule : ddmsc_selftest

// ==== rtl/ddmsc_top.sv ====
// Command decoder and sequencer for diagnostics, drive parameters and block transfers
//
// Overview of operation
// - Opcode 90H runs self-test, then puts the result code in the error register.
// - Codes: 01 ok, 02 n/a, 03 buffer, 04 controller, 05 CPU memory, 8X slave.
// - Self-test: ROM checksum, controller registers, incrementing RAM pattern written and read.
// - A master watches the shared passed-diagnostics line for the slave's outcome.
// - A slave pulls passed-diagnostics low only after passing its own diagnostics.
// - Diagnostics run on both drives even when the slave is selected.
// - Master drives the task file and waits at most five seconds for the slave.
// - After diagnostics the drive select bit is returned as zero.
// - Opcode 91H takes sectors per track from count, heads from drive/head.
// - Translation mode stays on whatever parameters are given.
// - Opcode C4H reads in blocks, ignores long mode, always retries.
// - Opcode C5H writes in blocks, ignores long mode, always retries.
// - One data request and one interrupt per block of the set size, plus a completion interrupt on writes.
// - Sector count is the total sector count, 1 to 256, not blocks.
// - A shorter last block follows when the count is not a block multiple.
// - Block read or write without multiple mode enabled is aborted.
// - Host write data goes only to the base cache segment.
// - Cache segments holding written sectors are invalidated before the write ends.
// - Block size 1 to 8 accepted, above 8 aborts, zero disables.
`timescale 1ns/10ps
`include "ddmsc_defines.svh"

module ddmsc_top #(
  parameter int PDIAG_WAIT_CYC = `DDMSC_PDIAG_WAIT_CYC,
  parameter int INT_BYTES      = `DDMSC_INT_RAM_BYTES,
  parameter int BUF_BYTES      = `DDMSC_BUF_RAM_BYTES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Task-file command strobe and registers
  input  wire logic        cmdStrobe,
  input  wire logic [7:0]  cmdOpcode,
  input  wire logic [7:0]  secCountIn,
  input  wire logic [7:0]  driveHeadIn,
  // Drive role strap, high for slave
  input  wire logic        slaveCfg,
  // Passed-diagnostics open-drain pin
  input  wire logic        pdiagIn,
  output logic             pdiagOut,
  output logic             pdiagOe_n,
  // Status towards the host
  output logic             busy,
  output logic             drq,
  output logic             irqPulse,
  output logic             cmdDonePulse,
  output logic [7:0]       errCode,
  output logic [7:0]       drive_head_select_register,
  output logic             taskFileDrive,
  // Host data movement
  output logic [3:0]       blkSectors,
  input  wire logic        blkXferDone,
  // Drive configuration
  output logic [7:0]       sectors_per_track,
  output logic [3:0]       headCount,
  output logic             translateMode,
  output logic [3:0]       blockSize,
  output logic             multiModeOn,
  // Disk controller and cache
  output logic             diskStartPulse,
  output logic             diskWrite,
  output logic [8:0]       diskCount,
  output logic             retryEn,
  output logic             longMode,
  output logic             wrBaseSegment,
  output logic             cacheInvReq,
  input  wire logic        cacheInvAck,
  input  wire logic        secReadyPulse,
  input  wire logic        diskWrDone,
  // Self-test units and RAM port
  output logic             romChkReq,
  input  wire logic        romChkDone,
  input  wire logic        romChkOk,
  output logic             ctlTstReq,
  input  wire logic        ctlTstDone,
  input  wire logic        ctlTstOk,
  output logic             memSel,
  output logic [14:0]      memAddr,
  output logic             memWe,
  output logic             memRe,
  output logic [7:0]       memWrData,
  input  wire logic [7:0]  memRdData
);

  if (PDIAG_WAIT_CYC < 1) begin : g_bad_wait
    $error("ddmsc_top: PDIAG_WAIT_CYC must be at least one");
  end

  localparam int WW = $clog2(PDIAG_WAIT_CYC + 1);

  ddmsc_pkg::ddmsc_state_t state_r;
  logic [WW-1:0] waitCnt_r;
  logic          pdiagMeta_r;
  logic          pdiagSync_r;
  logic          isWrite_r;
  logic [8:0]    remain_r;
  logic [8:0]    ready_r;
  logic [8:0]    thisBlk;
  logic          invDone_r;
  logic          wrDone_r;
  logic          tstStart;
  logic          tstDone;
  logic [7:0]    tstCode;
  logic          selected;
  logic          accept;
  logic          lastBlk;
  logic [8:0]    totalCnt;

  // Commands other than diagnostics are taken only by the addressed drive
  assign selected = (driveHeadIn[`DDMSC_DRV_BIT] == slaveCfg);
  assign accept   = cmdStrobe && (state_r == ddmsc_pkg::ST_IDLE);
  assign totalCnt = (secCountIn == 8'h00) ? `DDMSC_FULL_COUNT : {1'b0, secCountIn};
  assign tstStart = accept && cmdOpcode == `DDMSC_OP_DIAG;

  // Size of the block now in flight: the set size, or what is left
  always_comb begin
    if (remain_r < {5'h00, blockSize}) thisBlk = remain_r;
    else thisBlk = {5'h00, blockSize};
  end
  assign lastBlk    = (remain_r == thisBlk);
  assign blkSectors = thisBlk[3:0];

  // Handshake and fixed mode outputs
  assign drq           = (state_r == ddmsc_pkg::ST_XF_DRQ);
  assign busy          = (state_r != ddmsc_pkg::ST_IDLE);
  assign translateMode = 1'b1;
  assign multiModeOn   = (blockSize != 4'h0);
  assign retryEn       = 1'b1;
  assign longMode      = 1'b0;
  assign wrBaseSegment = isWrite_r && busy;
  assign pdiagOut      = 1'b0;

  // Two-stage synchroniser for the shared diagnostics line
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pdiagMeta_r <= 1'b1;
      pdiagSync_r <= 1'b1;
    end else begin
      pdiagMeta_r <= pdiagIn;
      pdiagSync_r <= pdiagMeta_r;
    end
  end

  ddmsc_selftest #(
    .INT_BYTES (INT_BYTES),
    .BUF_BYTES (BUF_BYTES)
  ) u_selftest (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .start      (tstStart),
    .done       (tstDone),
    .resultCode (tstCode),
    .romChkReq  (romChkReq),
    .romChkDone (romChkDone),
    .romChkOk   (romChkOk),
    .ctlTstReq  (ctlTstReq),
    .ctlTstDone (ctlTstDone),
    .ctlTstOk   (ctlTstOk),
    .memSel     (memSel),
    .memAddr    (memAddr),
    .memWe      (memWe),
    .memRe      (memRe),
    .memWrData  (memWrData),
    .memRdData  (memRdData)
  );

  // Main command sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ddmsc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        ddmsc_pkg::ST_IDLE: begin
          if (accept) begin
            if (cmdOpcode == `DDMSC_OP_DIAG) begin
              state_r <= ddmsc_pkg::ST_DIAG_RUN;
            end else if (!selected) begin
              state_r <= ddmsc_pkg::ST_IDLE;
            end else if (cmdOpcode == `DDMSC_OP_RD_MULTI && multiModeOn) begin
              state_r <= ddmsc_pkg::ST_XF_WAIT;
            end else if (cmdOpcode == `DDMSC_OP_WR_MULTI && multiModeOn) begin
              state_r <= ddmsc_pkg::ST_XF_DRQ;
            end else begin
              state_r <= ddmsc_pkg::ST_DONE;
            end
          end
        end
        ddmsc_pkg::ST_DIAG_RUN: begin
          if (tstDone) begin
            state_r <= slaveCfg ? ddmsc_pkg::ST_DONE : ddmsc_pkg::ST_DIAG_WAIT;
          end
        end
        ddmsc_pkg::ST_DIAG_WAIT: begin
          // Slave pass or the five second limit ends the wait
          if (!pdiagSync_r || waitCnt_r == WW'(PDIAG_WAIT_CYC)) begin
            state_r <= ddmsc_pkg::ST_DONE;
          end
        end
        ddmsc_pkg::ST_XF_WAIT: begin
          if (ready_r >= thisBlk) state_r <= ddmsc_pkg::ST_XF_DRQ;
        end
        ddmsc_pkg::ST_XF_DRQ: begin
          if (blkXferDone) begin
            if (isWrite_r) state_r <= ddmsc_pkg::ST_WR_DISK;
            else if (lastBlk) state_r <= ddmsc_pkg::ST_DONE;
            else state_r <= ddmsc_pkg::ST_XF_WAIT;
          end
        end
        ddmsc_pkg::ST_WR_DISK: begin
          // A block is finished only once its stale cache copies are gone
          if (wrDone_r && invDone_r) begin
            state_r <= lastBlk ? ddmsc_pkg::ST_DONE : ddmsc_pkg::ST_XF_DRQ;
          end
        end
        ddmsc_pkg::ST_DONE: state_r <= ddmsc_pkg::ST_IDLE;
        default:            state_r <= ddmsc_pkg::ST_IDLE;
      endcase
    end
  end

  // Slave five second timer; counts only while the master waits
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_r != ddmsc_pkg::ST_DIAG_WAIT) begin
      waitCnt_r <= '0;
    end else begin
      waitCnt_r <= waitCnt_r + WW'(1);
    end
  end

  // Passed-diagnostics drive: released at each new diagnostic, pulled on own pass when strapped as slave
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tstStart) begin
      pdiagOe_n <= 1'b1;
    end else if (state_r == ddmsc_pkg::ST_DIAG_RUN && tstDone && slaveCfg
                 && tstCode == `DDMSC_DIAG_OK) begin
      pdiagOe_n <= 1'b0;
    end
  end

  // Task-file ownership of the host bus
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      taskFileDrive <= 1'b0;
    end else if (accept) begin
      if (cmdOpcode == `DDMSC_OP_DIAG) taskFileDrive <= !slaveCfg;
      else taskFileDrive <= selected;
    end
  end

  // Error register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      errCode <= 8'h00;
    end else if (accept) begin
      errCode <= 8'h00;
    end else if (state_r == ddmsc_pkg::ST_DIAG_RUN && tstDone) begin
      errCode <= tstCode;
    end else if (state_r == ddmsc_pkg::ST_DIAG_WAIT && pdiagSync_r
                 && waitCnt_r == WW'(PDIAG_WAIT_CYC)) begin
      errCode <= {`DDMSC_DIAG_SLAVE, errCode[3:0]};
    end else if (accept_abort(state_r, multiModeOn)) begin
      errCode <= `DDMSC_ERR_ABORT;
    end
  end

  // Aborted commands are recognised on the cycle after acceptance
  logic [7:0] opHeld_r;
  logic [7:0] cntHeld_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      opHeld_r  <= 8'h00;
      cntHeld_r <= 8'h00;
    end else if (accept) begin
      opHeld_r  <= cmdOpcode;
      cntHeld_r <= secCountIn;
    end
  end

  function automatic logic accept_abort(ddmsc_pkg::ddmsc_state_t st, logic multi);
    accept_abort = 1'b0;
    if (st == ddmsc_pkg::ST_DONE) begin
      if ((opHeld_r == `DDMSC_OP_RD_MULTI || opHeld_r == `DDMSC_OP_WR_MULTI) && !multi)
        accept_abort = 1'b1;
      if (opHeld_r == `DDMSC_OP_SET_MULTI && cntHeld_r > {4'h0, `DDMSC_MAX_BLOCK})
        accept_abort = 1'b1;
    end
  endfunction : accept_abort

  // Drive/head register returned to the host
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_head_select_register <= 8'h00;
    end else if (accept) begin
      drive_head_select_register <= driveHeadIn;
    end else if (state_r == ddmsc_pkg::ST_DONE && opHeld_r == `DDMSC_OP_DIAG) begin
      drive_head_select_register[`DDMSC_DRV_BIT] <= 1'b0;
    end
  end

  // Geometry and block size configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sectors_per_track <= `DDMSC_SPT_RST;
      headCount         <= `DDMSC_HEADS_RST;
      blockSize         <= 4'h0;
    end else if (accept && selected) begin
      if (cmdOpcode == `DDMSC_OP_SET_PARAM) begin
        sectors_per_track <= secCountIn;
        headCount         <= driveHeadIn[3:0] + 4'h1;
      end
      // Oversized block request leaves the old size in force
      if (cmdOpcode == `DDMSC_OP_SET_MULTI && secCountIn <= {4'h0, `DDMSC_MAX_BLOCK}) begin
        blockSize <= secCountIn[3:0];
      end
    end
  end

  // Transfer bookkeeping: sectors left and sectors waiting in cache
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      isWrite_r <= 1'b0;
      remain_r  <= 9'h000;
      ready_r   <= 9'h000;
    end else if (accept) begin
      isWrite_r <= (cmdOpcode == `DDMSC_OP_WR_MULTI);
      remain_r  <= totalCnt;
      ready_r   <= 9'h000;
    end else begin
      if (state_r == ddmsc_pkg::ST_XF_DRQ && blkXferDone && !isWrite_r) begin
        remain_r <= remain_r - thisBlk;
        ready_r  <= ready_r - thisBlk + {8'h00, secReadyPulse};
      end else begin
        if (state_r == ddmsc_pkg::ST_WR_DISK && wrDone_r && invDone_r) begin
          remain_r <= remain_r - thisBlk;
        end
        ready_r <= ready_r + {8'h00, secReadyPulse};
      end
    end
  end

  // Disk start requests: one read of the whole count, or one write per block
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      diskStartPulse <= 1'b0;
      diskWrite      <= 1'b0;
      diskCount      <= 9'h000;
    end else begin
      diskStartPulse <= 1'b0;
      if (accept && selected && cmdOpcode == `DDMSC_OP_RD_MULTI && multiModeOn) begin
        diskStartPulse <= 1'b1;
        diskWrite      <= 1'b0;
        diskCount      <= totalCnt;
      end else if (state_r == ddmsc_pkg::ST_XF_DRQ && blkXferDone && isWrite_r) begin
        diskStartPulse <= 1'b1;
        diskWrite      <= 1'b1;
        diskCount      <= thisBlk;
      end
    end
  end

  // Disk write completion, held until the block is retired; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n || accept) begin
      wrDone_r <= 1'b0;
    end else if (diskWrDone) begin
      wrDone_r <= 1'b1;
    end else if (state_r == ddmsc_pkg::ST_WR_DISK && invDone_r) begin
      wrDone_r <= 1'b0;
    end
  end

  // Cache invalidation for the written range, raised as the write starts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cacheInvReq <= 1'b0;
      invDone_r   <= 1'b0;
    end else if (accept) begin
      cacheInvReq <= selected && cmdOpcode == `DDMSC_OP_WR_MULTI && multiModeOn;
      invDone_r   <= 1'b0;
    end else if (cacheInvReq && cacheInvAck) begin
      cacheInvReq <= 1'b0;
      invDone_r   <= 1'b1;
    end
  end

  // Interrupt per block on data request, and at completion of any command but a block read when this drive holds the task file
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqPulse     <= 1'b0;
      cmdDonePulse <= 1'b0;
    end else begin
      irqPulse <= ((state_r == ddmsc_pkg::ST_XF_WAIT && ready_r >= thisBlk)
                   || (state_r == ddmsc_pkg::ST_IDLE && accept && selected
                       && cmdOpcode == `DDMSC_OP_WR_MULTI && multiModeOn)
                   || (state_r == ddmsc_pkg::ST_WR_DISK && wrDone_r && invDone_r
                       && !lastBlk))
                  || (state_r == ddmsc_pkg::ST_DONE && taskFileDrive
                      && opHeld_r != `DDMSC_OP_RD_MULTI);
      cmdDonePulse <= (state_r == ddmsc_pkg::ST_DONE);
    end
  end

endmodule : ddmsc_top

// ==== test/ddmsc_checker_sva.sv ====
// Port-level assertions for the command sequencer
`timescale 1ns/10ps
module ddmsc_checker (
  // Clock, reset and command
  input logic       ref_clk,
  input logic       rst_n,
  input logic       cmdStrobe,
  input logic [7:0] cmdOpcode,
  input logic [7:0] driveHeadIn,
  input logic       slaveCfg,
  // Status and configuration
  input logic       busy,
  input logic       drq,
  input logic       irqPulse,
  input logic [7:0] errCode,
  input logic       pdiagOe_n,
  input logic [3:0] blockSize,
  input logic       multiModeOn,
  input logic       translateMode,
  input logic       retryEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Command taken by this drive; diagnostics ignore the select bit
  wire logic take = cmdStrobe && !busy && driveHeadIn[4] == slaveCfg;
  a_diag_any_drive: assert property (cmdStrobe && !busy && cmdOpcode == 8'h90 |=> busy)
    else $error("diagnostics not started");
  a_xlate_always: assert property (translateMode)
    else $error("translation mode off");
  a_retry_always: assert property (busy |-> retryEn)
    else $error("retries disabled");
  a_size_max: assert property (blockSize <= 4'h8)
    else $error("block size above limit");
  a_multi_flag: assert property (multiModeOn == (blockSize != 4'h0))
    else $error("multiple mode flag wrong");
  a_drq_irq_pair: assert property ($rose(drq) |-> irqPulse)
    else $error("data request without interrupt");
  a_slave_pulls: assert property ($fell(pdiagOe_n) |-> slaveCfg ##[0:2] errCode == 8'h01)
    else $error("passed line pulled wrongly");
  a_abort_nomulti: assert property (
    take && cmdOpcode[7:1] == 7'h62 && !multiModeOn |-> ##[1:4] errCode == 8'h04)
    else $error("block command not aborted");
endmodule : ddmsc_checker

bind ddmsc_top ddmsc_checker ddmsc_checker_inst (.ref_clk, .rst_n, .cmdStrobe, .cmdOpcode,
  .driveHeadIn, .slaveCfg, .busy, .drq, .irqPulse, .errCode, .pdiagOe_n, .blockSize,
  .multiModeOn, .translateMode, .retryEn);

// ==== test/ddmsc_partner.sv ====
// Far-side model: test units, RAM, disk controller and cache
`timescale 1ns/10ps
module ddmsc_partner (
  // Clock and reset
  input  logic        ref_clk,
  input  logic        rst_n,
  // Self-test units and RAM
  input  logic        romChkReq,
  output logic        romChkDone,
  output logic        romChkOk,
  input  logic        ctlTstReq,
  output logic        ctlTstDone,
  output logic        ctlTstOk,
  input  logic        memSel,
  input  logic [14:0] memAddr,
  input  logic        memWe,
  input  logic        memRe,
  input  logic [7:0]  memWrData,
  output logic [7:0]  memRdData,
  // Disk controller and cache
  input  logic        diskStartPulse,
  input  logic        diskWrite,
  input  logic [8:0]  diskCount,
  input  logic        cacheInvReq,
  output logic        cacheInvAck,
  output logic        secReadyPulse,
  output logic        diskWrDone
);
  logic [7:0] mem [0:511];
  logic [8:0] left;
  logic       wrOp;
  assign romChkOk = 1'b1;
  assign ctlTstOk = 1'b1;
  // Units pass; idle read data is inverted so a stale byte never passes
  always_ff @(posedge ref_clk) begin
    romChkDone <= romChkReq && !romChkDone;
    ctlTstDone <= ctlTstReq && !ctlTstDone;
    if (memWe) mem[{memSel, memAddr[7:0]}] <= memWrData;
    memRdData <= memRe ? mem[{memSel, memAddr[7:0]}] : ~memRdData;
  end
  // One sector a cycle on reads; write done after diskCount cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      left <= 9'h000;
      wrOp <= 1'b0;
    end else if (diskStartPulse) begin
      left <= diskCount;
      wrOp <= diskWrite;
    end else if (left != 9'h000) begin
      left <= left - 9'h001;
    end
    secReadyPulse <= !wrOp && left != 9'h000 && !diskStartPulse;
    diskWrDone    <= wrOp && left == 9'h001;
    cacheInvAck   <= cacheInvReq;
  end
endmodule : ddmsc_partner

// ==== test/tb.sv ====
// Self-checking bench of the command sequencer
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, cmdStrobe = 1'b0, slaveCfg = 1'b0, blkXferDone = 1'b0;
  logic slvPull = 1'b0;
  logic [7:0] cmdOpcode = 8'h00, secCountIn = 8'h00, driveHeadIn = 8'h00;
  logic pdiagIn, pdiagOut, pdiagOe_n, busy, drq, irqPulse, cmdDonePulse, taskFileDrive;
  logic translateMode, multiModeOn, diskStartPulse, diskWrite, retryEn, longMode, wrBaseSegment;
  logic cacheInvReq, cacheInvAck, secReadyPulse, diskWrDone, romChkReq, romChkDone, romChkOk;
  logic ctlTstReq, ctlTstDone, ctlTstOk, memSel, memWe, memRe;
  logic [7:0] errCode, drive_head_select_register, sectors_per_track, memWrData, memRdData;
  logic [3:0] blkSectors, headCount, blockSize;
  logic [8:0] diskCount;
  logic [14:0] memAddr;
  int mismatches = 0, cmp_count = 0, nIrq, nBlk;
  // Clock, and the shared passed line with its pull-up
  always #25 ref_clk = ~ref_clk;
  assign pdiagIn = (pdiagOe_n ? 1'b1 : pdiagOut) & ~slvPull;
  ddmsc_top #(.PDIAG_WAIT_CYC(50), .INT_BYTES(16), .BUF_BYTES(32)) ddmsc_top_inst (.*);
  ddmsc_partner ddmsc_partner_inst (.*);
  task automatic chk(input string nm, input logic [8:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  function automatic int blocks_of(int tot, int bs);
    return (tot + bs - 1) / bs;
  endfunction : blocks_of
  // Host side: one command, each data request served by a block pulse
  task automatic run_cmd(input logic [7:0] op, cnt, dhv);
    int i;
    {i, nIrq, nBlk} = 0;
    @(negedge ref_clk);
    {cmdOpcode, secCountIn, driveHeadIn, cmdStrobe} = {op, cnt, dhv, 1'b1};
    do begin
      @(negedge ref_clk);
      cmdStrobe = 1'b0;
      nIrq += int'(irqPulse === 1'b1);
      if (drq === 1'b1) chk("seg", {8'h00, op[0]}, {8'h00, wrBaseSegment});
      blkXferDone = drq === 1'b1 && !blkXferDone;
      nBlk += int'(blkXferDone);
      i++;
    end while (busy === 1'b1 && i < 5000);
    chk("done", {8'h00, op == 8'h90 || dhv[4] == slaveCfg}, {8'h00, cmdDonePulse});
  endtask : run_cmd
  initial begin
    int k, bs, n, tot, nb;
    logic [7:0] v;
    k = $urandom(62658);
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("spt", 9'h011, {1'b0, sectors_per_track});
    chk("heads", 9'h00a, {5'h00, headCount});
    for (k = 0; k < 2; k++) begin
      run_cmd(8'hc4 + 8'(k), 8'h05, 8'h00);
      chk("abort", 9'h004, {1'b0, errCode});
    end
    // Recommended geometry first, then random ones
    for (k = 0; k < 3; k++) begin
      v = k == 0 ? 8'h11 : 8'($urandom);
      n = k == 0 ? 9 : $urandom_range(0, 14);
      run_cmd(8'h91, v, 8'(n));
      chk("spt", {1'b0, v}, {1'b0, sectors_per_track});
      chk("heads", 9'(n + 1), {5'h00, headCount});
      chk("xlate", 9'h001, {8'h00, translateMode});
    end
    run_cmd(8'hc6, 8'h09, 8'h00);
    chk("bsize", 9'h000, {5'h00, blockSize});
    chk("abort", 9'h004, {1'b0, errCode});
    // Block reads and writes; an unselected size command must be ignored
    for (k = 0; k < 8; k++) begin
      bs = k < 2 ? 8 : $urandom_range(1, 8);
      n = k == 0 ? 0 : k == 2 ? 1 : $urandom_range(1, 255);
      run_cmd(8'hc6, 8'(bs), 8'h00);
      run_cmd(8'hc6, 8'h03, 8'h10);
      chk("bsize", 9'(bs), {5'h00, blockSize});
      tot = n == 0 ? 256 : n;
      nb = blocks_of(tot, bs);
      run_cmd(8'hc4 + 8'(k % 2), 8'(n), 8'h00);
      chk("blocks", 9'(nb), 9'(nBlk));
      chk("irqs", 9'(nb + k % 2), 9'(nIrq));
      chk("count", 9'(k % 2 ? tot - (nb - 1) * bs : tot), diskCount);
    end
    // Master alone times out, master with passing slave, then a slave drive
    for (k = 0; k < 3; k++) begin
      slvPull = k == 1;
      slaveCfg = k == 2;
      run_cmd(8'h90, 8'($urandom), 8'h10 | 8'($urandom_range(0, 15)));
      chk("diag", k == 0 ? 9'h081 : 9'h001, {1'b0, errCode});
      chk("select", 9'h000, {8'h00, drive_head_select_register[4]});
      chk("tfd", {8'h00, k != 2}, {8'h00, taskFileDrive});
    end
    chk("pull", 9'h000, {8'h00, pdiagOe_n});
    report_and_stop();
  end
  // Hang guard
  initial begin
    #(50 * 60000);
    mismatches++;
    report_and_stop();
  end
endmodule : tb
